// ==== rtl/prox_readout.sv ====
// proximity status flags and coherent 16-bit result readout registers
`timescale 1ns/1ps
`default_nettype none

module prox_readout
  import prox_readout_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH   = prox_readout_pkg::ADDR_W,
  parameter int unsigned RESULT_WIDTH = prox_readout_pkg::RESULT_W
)
(
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire logic                     prox_irq_flag,
  input  wire logic                     result_valid,
  input  wire logic [RESULT_WIDTH-1:0]  result_data,
  input  wire logic [ADDR_WIDTH-1:0]    reg_addr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_wr,
  input  wire logic [prox_readout_pkg::DATA_W-1:0] reg_wdata,
  output var  logic [prox_readout_pkg::DATA_W-1:0] reg_rdata,
  output var  logic                     reg_rvalid
);
  import prox_readout_pkg::*;

  logic                    rst_meta_n_r;
  logic                    rst_sync_n_r;
  logic [RESULT_WIDTH-1:0] result_r;
  logic [DATA_W-1:0]       shadow_r;
  logic [DATA_W-1:0]       rdata_nxt;
  logic                    unused_wdata;
  reg_sel_type             rd_sel;

  // address decode for the read path; writes are never decoded
  function automatic reg_sel_type decode(input logic [ADDR_WIDTH-1:0] addr);
    reg_sel_type sel;
    sel = SEL_NONE;
    if (addr == STATE_FLAGS_OFFSET)
    begin
      sel = SEL_FLAGS;
    end
    else if (addr == RESULT_LOW_OFFSET)
    begin
      sel = SEL_LOW;
    end
    else if (addr == RESULT_HIGH_OFFSET)
    begin
      sel = SEL_HIGH;
    end
    return sel;
  endfunction

  // reset released through two flops so release is clean against clock
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_n_r <= 1'b1;
      rst_sync_n_r <= rst_meta_n_r;
    end
  end

  assign rd_sel = decode(reg_addr);
  // every slice register is read-only, so write strobe and data are
  // only sunk here; nothing in the slice can be written
  assign unused_wdata = ^{reg_wr, reg_wdata}; // R1

  // latest conversion result; writes never reach it
  always_ff @(posedge clock or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
    begin
      result_r <= RESULT_RESET;
    end
    else if (result_valid)
    begin
      result_r <= result_data; // R3
    end
  end

  // shadow taken from the same result word the low byte comes from,
  // so a conversion finishing mid-transfer cannot tear the pair
  always_ff @(posedge clock or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
    begin
      shadow_r <= SHADOW_RESET;
    end
    else if (reg_rd && rd_sel == SEL_LOW)
    begin
      shadow_r <= result_r[RESULT_WIDTH-1 -: DATA_W]; // R4
    end
  end

  // read data mux; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = UNMAPPED_READ;
    unique case (rd_sel)
      SEL_FLAGS:
      begin
        rdata_nxt = UNMAPPED_READ;              // R7
        rdata_nxt[IRQ_FLAG_BIT] = prox_irq_flag; // R2
      end
      SEL_LOW:
      begin
        rdata_nxt = result_r[DATA_W-1:0]; // R3
      end
      SEL_HIGH:
      begin
        rdata_nxt = shadow_r; // R5
      end
      SEL_NONE:
      begin
        rdata_nxt = UNMAPPED_READ;
      end
    endcase
  end

  // registered answer, one cycle after the read strobe
  always_ff @(posedge clock or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
    begin
      reg_rdata  <= RDATA_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // status read tracks the interrupt level of the strobe cycle
  property p_irq_flag_read;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == STATE_FLAGS_OFFSET)
      |=> (reg_rvalid && reg_rdata[IRQ_FLAG_BIT] == $past(prox_irq_flag));
  endproperty
  a_irq_flag_read: assert property (p_irq_flag_read) // R2
    else $error("status bit 5 does not follow the interrupt level");

  property p_reserved_zero;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == STATE_FLAGS_OFFSET)
      |=> (reg_rdata[7:6] == 2'h0 && reg_rdata[4:0] == 5'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R7
    else $error("reserved status bits read nonzero");

  property p_low_read;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == RESULT_LOW_OFFSET)
      |=> (reg_rvalid && reg_rdata == $past(result_r[7:0]));
  endproperty
  a_low_read: assert property (p_low_read) // R3
    else $error("low byte read does not return the held result");

  property p_result_load;
    @(posedge clock) disable iff (!rst_sync_n_r)
      result_valid |=> (result_r == $past(result_data));
  endproperty
  a_result_load: assert property (p_result_load) // R3
    else $error("conversion result not captured");

  property p_shadow_capture;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == RESULT_LOW_OFFSET)
      |=> (shadow_r == $past(result_r[15:8]));
  endproperty
  a_shadow_capture: assert property (p_shadow_capture) // R4
    else $error("shadow not loaded from upper result bits");

  // low then high read pair returns one coherent word
  property p_pair_coherent;
    logic [15:0] word;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == RESULT_LOW_OFFSET, word = result_r)
      ##1 (reg_rd && reg_addr == RESULT_HIGH_OFFSET)
      |=> (reg_rdata == word[15:8]);
  endproperty
  a_pair_coherent: assert property (p_pair_coherent) // R5
    else $error("high byte not coherent with earlier low byte");

  property p_shadow_hold;
    @(posedge clock) disable iff (!rst_sync_n_r)
      !(reg_rd && reg_addr == RESULT_LOW_OFFSET) |=> $stable(shadow_r);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) // R5
    else $error("shadow changed without a low byte read");

  property p_write_ignored;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_wr && !reg_rd && !result_valid)
      |=> ($stable(result_r) && $stable(shadow_r) && !reg_rvalid);
  endproperty
  a_write_ignored: assert property (p_write_ignored) // R1
    else $error("host write altered readout state");

  // high byte answers from the shadow, never from the live result
  property p_high_read;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == RESULT_HIGH_OFFSET)
      |=> (reg_rvalid && reg_rdata == $past(shadow_r));
  endproperty
  a_high_read: assert property (p_high_read) // R5
    else $error("high byte read does not return the shadow");

  // without a read strobe the answer neither pulses nor changes
  property p_rdata_hold;
    @(posedge clock) disable iff (!rst_sync_n_r)
      !reg_rd |=> (!reg_rvalid && $stable(reg_rdata));
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) // R1
    else $error("read data changed without a read strobe");

  // a status read leaves result and shadow alone
  property p_flags_no_effect;
    @(posedge clock) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == STATE_FLAGS_OFFSET && !result_valid)
      |=> ($stable(shadow_r) && $stable(result_r));
  endproperty
  a_flags_no_effect: assert property (p_flags_no_effect) // R7
    else $error("status read disturbed readout state");

endmodule

`default_nettype wire

// ==== rtl/prox_readout_pkg.sv ====
// constants for the proximity status and result readout slice
//
// Function
// R1 - status register at 0x13 is read-only; host writes never change it
// R2 - status bit 5 reads one while the proximity interrupt is asserted
// R3 - result held as 16 bits; low byte at 0x18, high byte at 0x19
// R4 - reading the low byte copies the result's upper eight bits into a shadow
// R5 - reading the high byte returns the shadow, coherent with the earlier low byte
// R6 - host should read both bytes in one auto-increment transfer starting low
// R7 - reserved status bits 7:6 and 4:0 read zero with no side effect
`default_nettype none

package prox_readout_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RESULT_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] STATE_FLAGS_OFFSET = 5'h13;
  localparam logic [ADDR_W-1:0] RESULT_LOW_OFFSET = 5'h18;
  localparam logic [ADDR_W-1:0] RESULT_HIGH_OFFSET = 5'h19;

  // status field position
  localparam int unsigned IRQ_FLAG_BIT = 5;

  // reset values and the value read at unmapped offsets
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SHADOW_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // which register a bus address selects
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_LOW,
    SEL_HIGH
  } reg_sel_type;

endpackage

`default_nettype wire

// ==== tb/prox_host_model.sv ====
// host-side register reader standing in for the serial master
`timescale 1ns/1ps
`default_nettype none

module prox_host_model (
  input  wire logic       clock,
  output var  logic [4:0] reg_addr,
  output var  logic       reg_rd,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic       timed_out
);
  initial {reg_addr, reg_rd, reg_wr, reg_wdata, timed_out} = '0;

  // one read strobe, driven and released on falling edges
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int i;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a; // stale address would hide a late sample
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
      @(negedge clock);
    timed_out = (reg_rvalid !== 1'b1);
    d = reg_rdata;
    // let an edge pass so a following call never re-drives in this step
    @(negedge clock);
  endtask

  // one write strobe; data inverted once released
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(negedge clock);
  endtask

  // auto-increment two-byte fetch, low byte first, strobe held across both
  task automatic rd_pair(output logic [7:0] lo, output logic [7:0] hi);
    reg_addr = 5'h18;
    reg_rd = 1'b1;
    @(negedge clock);
    if (reg_rvalid !== 1'b1)
      timed_out = 1'b1;
    lo = reg_rdata;
    reg_addr = 5'h19;
    @(negedge clock);
    if (reg_rvalid !== 1'b1)
      timed_out = 1'b1;
    hi = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    @(negedge clock);
  endtask
endmodule

`default_nettype wire

// ==== tb/prox_readout_test.sv ====
// self-checking bench for the proximity readout slice
`timescale 1ns/1ps
`default_nettype none

module prox_readout_test;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        prox_irq_flag = 1'b0;
  logic        result_valid = 1'b0;
  logic [15:0] result_data = 16'h0000;
  logic [4:0]  reg_addr;
  logic        reg_rd;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        timed_out;
  logic [7:0]  lo;
  logic [7:0]  hi;
  int          fail_count = 0;
  int          checked = 0;

  initial forever #2.5 clock = ~clock;

  prox_readout i_prox_readout (.clock(clock), .reset_n(reset_n),
    .prox_irq_flag(prox_irq_flag), .result_valid(result_valid),
    .result_data(result_data), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  prox_host_model i_prox_host_model (.clock(clock), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .timed_out(timed_out));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // conversion result pulse, one cycle wide
  task automatic load(input logic [15:0] d);
    result_data = d;
    result_valid = 1'b1;
    @(negedge clock);
    result_valid = 1'b0;
    result_data = ~d;
  endtask

  // a read that ran out of its bound ends the run
  always @(posedge timed_out)
  begin
    fail_count++;
    wrap_up();
  end

  task automatic t_status();
    prox_irq_flag = 1'b1;
    i_prox_host_model.rd(5'h13, lo);
    check(lo, 8'h20);
    check({7'h00, reg_rvalid}, 8'h00);
    i_prox_host_model.wr(5'h13, 8'hdf);
    check({7'h00, reg_rvalid}, 8'h00);
    i_prox_host_model.rd(5'h13, lo);
    check(lo, 8'h20);
    prox_irq_flag = 1'b0;
    i_prox_host_model.rd(5'h13, lo);
    check(lo, 8'h00);
    i_prox_host_model.rd(5'h1f, lo);
    check(lo, 8'h00);
    $display("test status done");
  endtask

  task automatic t_result();
    load(16'ha55a);
    i_prox_host_model.rd_pair(lo, hi);
    check(lo, 8'h5a);
    check(hi, 8'ha5);
    $display("test result done");
  endtask

  // new conversion lands between the low and high reads
  task automatic t_coherent();
    load(16'h1234);
    i_prox_host_model.rd(5'h18, lo);
    check(lo, 8'h34);
    load(16'hbeef);
    i_prox_host_model.rd(5'h19, hi);
    check(hi, 8'h12);
    i_prox_host_model.rd(5'h19, hi);
    check(hi, 8'h12);
    i_prox_host_model.rd_pair(lo, hi);
    check(lo, 8'hef);
    check(hi, 8'hbe);
    $display("test coherent done");
  endtask

  // mid-run reset clears result, shadow and read data
  task automatic t_reset();
    load(16'hc3a5);
    i_prox_host_model.rd(5'h18, lo);
    check(lo, 8'ha5);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    check(reg_rdata, 8'h00);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    i_prox_host_model.rd(5'h19, hi);
    check(hi, 8'h00);
    i_prox_host_model.rd(5'h18, lo);
    check(lo, 8'h00);
    $display("test reset done");
  endtask

  initial
  begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_status();
    t_result();
    t_coherent();
    t_reset();
    wrap_up();
  end
endmodule

`default_nettype wire
